// File: logic/csb_defines.svh
/*
 * Constants of the short conditional branch unit: opcodes, flag positions,
 * displacement masks and clock counts.
 * Assumes it is included by bare name from csb_branch_unit.
 */
// Notes on behaviour
// RULE_01: Opcode 72 with a displacement byte branches when the carry flag is one.
// RULE_02: Opcode 76 with a displacement byte branches when carry or zero flag is one.
// RULE_03: Opcode E3 with a displacement byte branches only when the count register is zero.
// RULE_04: A false condition continues at the next sequential instruction.
// RULE_05: A taken branch sign-extends the displacement by filling the upper byte.
// RULE_06: A taken branch adds the extended displacement to the pointer modulo 2^16.
// RULE_07: None of these branches alters any status flag, taken or not.
// RULE_08: The carry and carry-or-zero forms last 13 clocks taken and 4 clocks not taken.
// RULE_09: The count-zero form lasts 15 clocks taken and 5 clocks not taken.
// RULE_10: Synonym names share an opcode and the unit tells branches apart by opcode alone.
// RULE_11: Software reaching beyond the 8-bit range skips a long jump with the inverse branch.
// RULE_12: The displacement is the byte after the opcode, relative to the next instruction.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

`define CSB_OP_BELOW       8'h72
`define CSB_OP_BELOW_EQ    8'h76
`define CSB_OP_COUNT_ZERO  8'hE3

`define CSB_CARRY_BIT      0
`define CSB_ZERO_BIT       6

`define CSB_EXT_NEG_MASK   16'hFF00
`define CSB_EXT_POS_MASK   16'h00FF
`define CSB_INSTR_LEN      16'h0002
`define CSB_COUNT_ZERO_VAL 16'h0000

`define CSB_FLAG_TAKEN_CLK 5'h0D
`define CSB_FLAG_SKIP_CLK  5'h04
`define CSB_CNT_TAKEN_CLK  5'h0F
`define CSB_CNT_SKIP_CLK   5'h05
`define CSB_TMR_BIAS       5'h02
`define CSB_LAST_BIAS      5'h01

`endif

// File: logic/csb_pkg.sv
/*
 * Types of the short conditional branch unit.
 * Assumes csb_defines.svh is on the include path.
 */
`default_nettype none
package csb_pkg;
   // One byte from the prefetch stream with its valid bit
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } csb_byte_t;

   // Result handed back to the core when the branch completes
   typedef struct packed {
      logic        taken;
      logic [15:0] instr_ptr;
      logic [15:0] flags;
   } csb_result_t;

   typedef enum logic {CSB_IDLE, CSB_RUN} csb_state_t;
endpackage
`default_nettype wire

// File: logic/csb_cycle_timer.sv
/*
 * Down counter that paces a branch to the clock count of its form.
 * Assumes load arrives as a single-cycle pulse from the same clock domain.
 */
`default_nettype none
module csb_cycle_timer (
   input  wire logic       clk_i,      // Core clock
   input  wire logic       sys_rst_i,  // Async reset, active high
   input  wire logic       load_i,     // Start a new count
   input  wire logic [4:0] load_val_i, // Cycles to wait
   output logic            zero_o      // Count has run out
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;

   // Saturate at zero so a late displacement simply waits
   assign cnt_nxt = load_i ? load_val_i : ((cnt_r == 5'h00) ? 5'h00 : 5'(cnt_r - 5'h01));
   assign zero_o  = (cnt_r == 5'h00);

   // Counter register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // csb_cycle_timer
`default_nettype wire

// File: logic/csb_branch_unit.sv
/*
 * Decode and execute of the short conditional branches on carry, on
 * carry-or-zero and on count register zero.
 * Assumes the prefetch stream and core state arrive from the same clock.
 */
`default_nettype none
`include "csb_defines.svh"
module csb_branch_unit (
   input  wire logic                 clk_i,          // Core clock, 10 MHz
   input  wire logic                 sys_rst_i,      // Async reset, active high
   input  wire csb_pkg::csb_byte_t   opcode_i,       // Opcode byte offer
   output logic                      opcode_ready_o, // Opcode accepted
   input  wire csb_pkg::csb_byte_t   disp_i,         // Displacement byte offer
   output logic                      disp_ready_o,   // Displacement accepted
   input  wire logic [15:0]          instr_ptr_i,    // Address of the opcode byte
   input  wire logic [15:0]          flags_i,        // Status flags at decode
   input  wire logic [15:0]          count_reg_i,    // Count register at decode
   output logic                      done_o,         // Branch completes, one cycle
   output var csb_pkg::csb_result_t  result_o        // Outcome, registered
);
   // Decode is by opcode byte alone, so synonyms cannot differ
   function automatic logic is_ours(input logic [7:0] op);
      is_ours = (op == `CSB_OP_BELOW) || (op == `CSB_OP_BELOW_EQ) ||
                (op == `CSB_OP_COUNT_ZERO);                           // RULE_10
   endfunction

   function automatic logic is_count_form(input logic [7:0] op);
      is_count_form = (op == `CSB_OP_COUNT_ZERO);
   endfunction

   // Registered state of the branch in flight
   csb_pkg::csb_state_t state_r;
   csb_pkg::csb_state_t state_nxt;
   logic        taken_r;
   logic [15:0] instr_ptr_r;
   logic [7:0]  disp_seen_r;
   logic [15:0] flags_r;
   logic [15:0] target_r;
   logic        have_disp_r;
   logic [7:0]  op_r;
   logic        late_r;
   logic [4:0]  cyc_r;
   logic        tmr_zero;

   wire logic        idle     = (state_r == csb_pkg::CSB_IDLE);
   wire logic        accept   = idle && opcode_i.valid && is_ours(opcode_i.data);
   wire logic        carry_in = flags_i[`CSB_CARRY_BIT];
   wire logic        zero_in  = flags_i[`CSB_ZERO_BIT];

   // Condition selection per opcode
   wire logic cond_below  = carry_in;                                  // RULE_01
   wire logic cond_beq    = carry_in | zero_in;                        // RULE_02
   wire logic cond_cnt    = (count_reg_i == `CSB_COUNT_ZERO_VAL);      // RULE_03
   wire logic cond_now    = (opcode_i.data == `CSB_OP_BELOW)    ? cond_below :
                            (opcode_i.data == `CSB_OP_BELOW_EQ) ? cond_beq   : cond_cnt;

   // Clock count chosen at decode; the timer ends two cycles short of it
   wire logic [4:0] flag_clk = cond_now ? `CSB_FLAG_TAKEN_CLK : `CSB_FLAG_SKIP_CLK; // RULE_08
   wire logic [4:0] cnt_clk  = cond_now ? `CSB_CNT_TAKEN_CLK : `CSB_CNT_SKIP_CLK;   // RULE_09
   wire logic [4:0] tmr_val  = 5'((is_count_form(opcode_i.data) ? cnt_clk : flag_clk)
                                  - `CSB_TMR_BIAS);

   // Displacement handshake and completion
   wire logic disp_take = !idle && !have_disp_r && disp_i.valid;       // RULE_12
   assign opcode_ready_o = idle && opcode_i.valid && is_ours(opcode_i.data);
   assign disp_ready_o   = !idle && !have_disp_r;
   assign done_o         = !idle && have_disp_r && tmr_zero;

   // Target: next instruction plus the sign-extended displacement
   wire logic [15:0] disp_w   = {8'h00, disp_i.data};
   wire logic [15:0] ext_disp = disp_i.data[7] ? (`CSB_EXT_NEG_MASK | disp_w)
                                               : (`CSB_EXT_POS_MASK & disp_w); // RULE_05
   wire logic [15:0] next_ptr = 16'(instr_ptr_r + `CSB_INSTR_LEN);             // RULE_12
   wire logic [15:0] jump_ptr = 16'(next_ptr + ext_disp);                      // RULE_06
   wire logic [15:0] target   = taken_r ? jump_ptr : next_ptr;                 // RULE_04

   // Next state; a branch leaves busy only on its completion pulse
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         csb_pkg::CSB_IDLE: begin
            if (accept) begin
               state_nxt = csb_pkg::CSB_RUN;
            end
         end
         csb_pkg::CSB_RUN: begin
            if (done_o) begin
               state_nxt = csb_pkg::CSB_IDLE;
            end
         end
         default: begin
            state_nxt = csb_pkg::CSB_IDLE;
         end
      endcase
   end

   csb_cycle_timer i_csb_cycle_timer (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .load_i     (accept),
      .load_val_i (tmr_val),
      .zero_o     (tmr_zero)
   );

   // Sequencer state
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= csb_pkg::CSB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Capture at decode; flags are only copied, never rewritten
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         taken_r     <= 1'b0;
         instr_ptr_r <= 16'h0000;
         flags_r     <= 16'h0000;
         op_r        <= 8'h00;
      end else if (accept) begin
         taken_r     <= cond_now;
         instr_ptr_r <= instr_ptr_i;
         flags_r     <= flags_i;                                       // RULE_07
         op_r        <= opcode_i.data;
      end
   end

   // Displacement capture; a late byte stretches the instruction
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         have_disp_r <= 1'b0;
         target_r    <= 16'h0000;
         late_r      <= 1'b0;
      end else begin
         have_disp_r <= disp_take ? 1'b1 : (done_o ? 1'b0 : have_disp_r);
         late_r      <= accept ? 1'b0 : (late_r | (disp_take & tmr_zero));
         if (disp_take) begin
            target_r <= target;
         end
      end
   end

   // Cycles since decode, read by the checks below
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cyc_r <= 5'h00;
      end else begin
         cyc_r <= accept ? `CSB_LAST_BIAS : (idle ? 5'h00 : 5'(cyc_r + 5'h01));
      end
   end

   assign result_o = '{taken: taken_r, instr_ptr: target_r, flags: flags_r};

   // Checker copy of the displacement byte, kept apart from the target path so that
   // the target check below does not lean on the logic that it judges
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         disp_seen_r <= 8'h00;
      end else if (disp_take) begin
         disp_seen_r <= disp_i.data;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Condition decisions, judged against the inputs seen at decode
   carry_cond_a: assert property (accept && opcode_i.data == `CSB_OP_BELOW   // RULE_01
      |=> taken_r == $past(flags_i[`CSB_CARRY_BIT])) else $error("carry branch decision wrong");
   below_eq_a: assert property (accept && opcode_i.data == `CSB_OP_BELOW_EQ // RULE_02
      |=> taken_r == ($past(flags_i[`CSB_CARRY_BIT]) | $past(flags_i[`CSB_ZERO_BIT])))
      else $error("carry-or-zero decision wrong");
   count_zero_a: assert property (accept && is_count_form(opcode_i.data)    // RULE_03
      |=> taken_r == ($past(count_reg_i) == `CSB_COUNT_ZERO_VAL))
      else $error("count zero decision wrong");

   // Targets of both outcomes
   fall_through_a: assert property (done_o && !taken_r                      // RULE_04
      |=> result_o.instr_ptr == 16'($past(instr_ptr_r) + `CSB_INSTR_LEN))
      else $error("fall-through target wrong");
   sign_extend_a: assert property (disp_take                                // RULE_05
      |-> ext_disp == {{8{disp_i.data[7]}}, disp_i.data})
      else $error("displacement extension wrong");
   target_sum_a: assert property (done_o && taken_r                         // RULE_06
      |-> result_o.instr_ptr ==
          16'(instr_ptr_r + `CSB_INSTR_LEN + {{8{disp_seen_r[7]}}, disp_seen_r}))
      else $error("branch target wrong");

   // Flags are only carried, never rewritten
   flags_kept_a: assert property (accept                                    // RULE_07
      ##1 (!done_o)[*2] |-> result_o.flags == $past(flags_i, 2)) else $error("flags changed");

   // Clock counts and the completion pulse
   flag_time_a: assert property (done_o && !late_r && !is_count_form(op_r)  // RULE_08
      |-> cyc_r == 5'((taken_r ? `CSB_FLAG_TAKEN_CLK : `CSB_FLAG_SKIP_CLK) - `CSB_LAST_BIAS))
      else $error("flag branch clock count wrong");
   count_time_a: assert property (done_o && !late_r && is_count_form(op_r)  // RULE_09
      |-> cyc_r == 5'((taken_r ? `CSB_CNT_TAKEN_CLK : `CSB_CNT_SKIP_CLK) - `CSB_LAST_BIAS))
      else $error("count branch clock count wrong");
   done_pulse_a: assert property (done_o                                    // RULE_08
      |=> !done_o) else $error("completion pulse too long");
   no_early_done_a: assert property (accept                                 // RULE_08
      |=> !done_o) else $error("completion before displacement");
   late_done_a: assert property (disp_take && tmr_zero                      // RULE_12
      |=> done_o) else $error("late displacement not finished");

   // Decode by opcode byte alone, one branch at a time
   decode_only_a: assert property (opcode_ready_o                           // RULE_10
      |-> opcode_i.data inside {`CSB_OP_BELOW, `CSB_OP_BELOW_EQ, `CSB_OP_COUNT_ZERO})
      else $error("foreign opcode accepted");
   busy_refuse_a: assert property (!idle                                    // RULE_10
      |-> !opcode_ready_o) else $error("opcode accepted while busy");
   own_accept_a: assert property (idle && opcode_i.valid                    // RULE_10
      && opcode_i.data inside {`CSB_OP_BELOW, `CSB_OP_BELOW_EQ, `CSB_OP_COUNT_ZERO}
      |-> opcode_ready_o) else $error("own opcode refused");

   taken_carry_c: cover property (accept && opcode_i.data == `CSB_OP_BELOW ##1 taken_r);
   skip_beq_c:    cover property (done_o && !taken_r && op_r == `CSB_OP_BELOW_EQ);
   count_take_c:  cover property (done_o && taken_r && is_count_form(op_r));
   late_disp_c:   cover property (done_o && late_r);
   disp_edge_c:   cover property (disp_take ##1 done_o);
endmodule // csb_branch_unit
`default_nettype wire

// File: bench/conditional_short_branch_tb_top.sv
/*
 * Self-checking testbench of the short conditional branch unit.
 * Assumes csb_pkg is compiled first and csb_defines.svh is on the include path.
 */
`default_nettype none
module conditional_short_branch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 clk_i       = 1'b0;
   logic                 sys_rst_i   = 1'b1;
   csb_pkg::csb_byte_t   opcode_i    = '0;
   csb_pkg::csb_byte_t   disp_i      = '0;
   logic [15:0]          instr_ptr_i = 16'h0000;
   logic [15:0]          flags_i     = 16'h0000;
   logic [15:0]          count_reg_i = 16'h0000;
   logic                 opcode_ready_o;
   logic                 disp_ready_o;
   logic                 done_o;
   csb_pkg::csb_result_t result_o;
   int                   miscompares = 0;
   int                   n_compared  = 0;

   csb_branch_unit i_csb_branch_unit (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .opcode_i(opcode_i),
      .opcode_ready_o(opcode_ready_o), .disp_i(disp_i), .disp_ready_o(disp_ready_o),
      .instr_ptr_i(instr_ptr_i), .flags_i(flags_i), .count_reg_i(count_reg_i), .done_o(done_o),
      .result_o(result_o));

   // 10 MHz core clock
   always #50 clk_i = ~clk_i;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("Compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One whole branch; inputs are scrambled after accept to prove they were sampled,
   // and wt idle cycles may pass before the displacement is offered
   task automatic run_br(input logic [7:0] op, input logic [15:0] fl, input logic [15:0] cnt,
                         input logic [15:0] ptr, input logic [7:0] d, input logic tk,
                         input int n, input int wt);
      int          cyc;
      int          exp_cyc;
      logic [15:0] exp_ptr;
      exp_ptr = ptr + 16'h0002 + (tk ? {{8{d[7]}}, d} : 16'h0000);
      // A late displacement ends the branch the cycle after it is taken
      exp_cyc = (wt + 2 > n - 1) ? wt + 2 : n - 1;
      @(negedge clk_i);
      opcode_i = '{valid: 1'b1, data: op};
      instr_ptr_i = ptr;
      flags_i = fl;
      count_reg_i = cnt;
      #1 chk("opcode_ready", 16'h0001, {15'h0000, opcode_ready_o});
      @(negedge clk_i);
      opcode_i.valid = 1'b0;
      flags_i = ~fl;
      count_reg_i = ~cnt;
      instr_ptr_i = ~ptr;
      cyc = 1;
      repeat (wt) begin
         @(negedge clk_i);
         cyc++;
      end
      disp_i = '{valid: 1'b1, data: d};
      #1 chk("disp_ready", 16'h0001, {15'h0000, disp_ready_o});
      @(negedge clk_i);
      disp_i = '{valid: 1'b0, data: ~d};
      cyc++;
      while (done_o !== 1'b1 && cyc < 40) begin
         @(negedge clk_i);
         cyc++;
      end
      chk("clock_count", 16'(exp_cyc), 16'(cyc));
      chk("taken", {15'h0000, tk}, {15'h0000, result_o.taken});
      chk("next_ptr", exp_ptr, result_o.instr_ptr);
      chk("flags", fl, result_o.flags);
      @(negedge clk_i);
      chk("done_pulse", 16'h0000, {15'h0000, done_o});
   endtask

   // The third call hops over a three-byte long jump, the way software reaches far targets
   task automatic t_carry();
      run_br(8'h72, 16'h0F01, 16'h1234, 16'h1000, 8'h80, 1'b1, 13, 0);
      run_br(8'h72, 16'hFFFE, 16'h0000, 16'h2000, 8'h10, 1'b0, 4, 0);
      run_br(8'h72, 16'h0001, 16'h0000, 16'h4000, 8'h03, 1'b1, 13, 0);
      run_br(8'h72, 16'h0001, 16'h0000, 16'h0500, 8'h10, 1'b1, 13, 11);
      $display("carry branch test done");
   endtask

   task automatic t_below_eq();
      run_br(8'h76, 16'h0001, 16'h0000, 16'h0100, 8'h05, 1'b1, 13, 0);
      run_br(8'h76, 16'h8A40, 16'h0000, 16'h0100, 8'hFE, 1'b1, 13, 0);
      run_br(8'h76, 16'hFFBE, 16'h0000, 16'h0100, 8'h05, 1'b0, 4, 0);
      run_br(8'h76, 16'h0040, 16'h0000, 16'h0700, 8'hC0, 1'b1, 13, 10);
      $display("carry or zero branch test done");
   endtask

   task automatic t_count();
      run_br(8'hE3, 16'h0000, 16'h0000, 16'hFFF0, 8'h7F, 1'b1, 15, 0);
      run_br(8'hE3, 16'hFFFF, 16'h0001, 16'h0300, 8'h20, 1'b0, 5, 0);
      run_br(8'hE3, 16'h0041, 16'h8000, 16'hFFFE, 8'h20, 1'b0, 5, 0);
      run_br(8'hE3, 16'h0000, 16'h0000, 16'h0800, 8'h01, 1'b1, 15, 14);
      $display("count zero branch test done");
   endtask

   // Reset in the middle of a branch drops it with no completion
   task automatic t_reset();
      @(negedge clk_i);
      opcode_i = '{valid: 1'b1, data: 8'h72};
      flags_i = 16'h0001;
      @(negedge clk_i);
      opcode_i.valid = 1'b0;
      disp_i = '{valid: 1'b1, data: 8'h20};
      @(negedge clk_i);
      disp_i.valid = 1'b0;
      sys_rst_i = 1'b1;
      #1 chk("reset_done", 16'h0000, {15'h0000, done_o});
      chk("reset_target", 16'h0000, result_o.instr_ptr);
      repeat (5) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (12) begin
         @(negedge clk_i);
         chk("reset_quiet", 16'h0000, {15'h0000, done_o});
      end
      run_br(8'h76, 16'h0040, 16'h0000, 16'h0600, 8'hF0, 1'b1, 13, 0);
      $display("mid-run reset test done");
   endtask

   // Neighbouring opcodes must be left alone
   task automatic t_refuse();
      logic [7:0] ops [4] = '{8'h74, 8'h73, 8'h77, 8'hE2};
      foreach (ops[i]) begin
         @(negedge clk_i);
         opcode_i = '{valid: 1'b1, data: ops[i]};
         flags_i = 16'hFFFF;
         repeat (3) begin
            #1 chk("refused_ready", 16'h0000, {15'h0000, opcode_ready_o});
            @(negedge clk_i);
            chk("refused_done", 16'h0000, {15'h0000, done_o});
         end
         opcode_i.valid = 1'b0;
      end
      $display("refused opcode test done");
   endtask

   // Watchdog sized well past the expected run
   initial begin
      repeat (3000) @(posedge clk_i);
      miscompares++;
      $display("BAD watchdog expected finish seen hang");
      complete_run();
   end

   // Main sequence
   initial begin
      repeat (5) @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_carry();
      t_below_eq();
      t_count();
      t_reset();
      t_refuse();
      complete_run();
   end
endmodule // conditional_short_branch_tb_top
`default_nettype wire
